//--- hdl/zsp_pkg.sv
// Shared constants and carrier types for the pipelined SRAM port.
package zsp_pkg;

    // Wide organisation: 512K words, four byte lanes.
    localparam int ZSP_ADDR_W = 19;
    localparam int ZSP_LANES = 4;
    localparam int ZSP_LANE_BITS = 8;
    // Lane in the array: byte in the low bits, its parity bit on top.
    localparam int ZSP_LANE_STORE = 9;
    // Widest supported shapes; the carriers are sized to them.
    localparam int ZSP_ADDR_MAX = 20;
    localparam int ZSP_LANES_MAX = 4;
    localparam int ZSP_FIFO_DEPTH = 8;
    // Burst counter step per beat; the two-bit count wraps after four.
    localparam logic [1:0] ZSP_BURST_STEP = 2'h1;
    localparam logic [1:0] ZSP_BURST_CNT_RST = 2'h0;
    localparam logic ZSP_OE_RST = 1'b0;

    // Gray codes along idle, read, write.
    typedef enum logic [1:0] {
        ZSP_IDLE = 2'b00,
        ZSP_READ = 2'b01,
        ZSP_WRITE = 2'b11
    } zsp_op_t;

    typedef struct packed {
        zsp_op_t op;
        logic [ZSP_ADDR_MAX-1:0] addr;
        logic [ZSP_LANES_MAX-1:0] bw_n;
    } zsp_cmd_t;

    localparam zsp_cmd_t ZSP_CMD_IDLE = '{op: ZSP_IDLE, addr: '0, bw_n: '1};

    typedef struct packed {
        zsp_op_t burst;
        logic [ZSP_ADDR_MAX-1:0] base;
        logic [1:0] start;
        logic [1:0] cnt;
        zsp_cmd_t s1;
        zsp_cmd_t s2;
        logic [ZSP_LANES_MAX*ZSP_LANE_BITS-1:0] dq;
        logic [ZSP_LANES_MAX-1:0] par;
        logic oe;
    } zsp_state_t;

endpackage

//--- hdl/zsp_sram_port.sv
// Pipelined zero-turnaround SRAM port with burst counter and read buffer.
//
// Functional notes
// - Advance/load high on an enabled edge steps the burst counter, no load.
// - Burst beats ignore read/write; direction comes from the load cycle.
// - Advance/load low with any select inactive starts a deselect cycle.
// - Data bus floats two cycles after a deselect, after pending transfers.
// - Clock enable high makes the edge invisible; all inputs ignored.
// - On a suspended edge pipeline, counter and driven data all hold.
// - Selected only when both low selects are low and the high select high.
// - Data outputs float from the first edge after power-up until a read.
// - Lane 1 writes bits 0:7 and parity 1; lane 2 bits 8:15 and parity 2.
// - Wide organisation adds lanes 3 and 4 for bits 16:23 and 24:31.
// - Any lane mix per write; all lanes high writes nothing; reads ignore.
// - Burst order pin high: low address bits are start XOR beat number.
// - Burst order pin low: low address bits count up modulo 4 from start.
// - Advancing past the fourth beat wraps and repeats the same order.
// - A read loaded at cycle n drives its word at n+2 if enabled.
// - Each burst read beat gives its data two cycles after its advance.
// - Any command mix back to back; each data phase two cycles later.
// - Enabled, load and selected loads an access; high read, low write.
// - Advance after deselect or no-op is a no-op; bus floats later.
`timescale 1ns/1ps

module zsp_fifo
    import zsp_pkg::*;
#(
    parameter int WIDTH = ZSP_LANES * ZSP_LANE_STORE,
    parameter int DEPTH = ZSP_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } zsp_fptr_t;

    zsp_fptr_t ptr_r;
    zsp_fptr_t ptr_nxt;
    logic [WIDTH-1:0] store [DEPTH];
    logic push;
    logic pop;

    // Full when the pointers differ only in their wrap bit.
    function automatic logic ptr_full(input zsp_fptr_t p);
        ptr_full = (p.wr[AW] != p.rd[AW]) && (p.wr[AW-1:0] == p.rd[AW-1:0]);
    endfunction

    // Empty when both pointers, wrap bit included, agree.
    function automatic logic ptr_empty(input zsp_fptr_t p);
        ptr_empty = (p.wr == p.rd);
    endfunction

    // Depth must be a power of two so the wrap bit tells full from empty.
    assign in_ready = !ptr_full(ptr_r);
    assign out_valid = !ptr_empty(ptr_r);
    assign out_data = store[ptr_r.rd[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        ptr_nxt = ptr_r;
        if (push) begin
            ptr_nxt.wr = ptr_r.wr + 1'b1;
        end
        if (pop) begin
            ptr_nxt.rd = ptr_r.rd + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_r <= '0;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            store[ptr_r.wr[AW-1:0]] <= in_data;
        end
    end

endmodule // zsp_fifo

module zsp_sram_port
    import zsp_pkg::*;
#(
    parameter int ADDR_W = ZSP_ADDR_W,
    parameter int LANES = ZSP_LANES,
    parameter int BUF_DEPTH = ZSP_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // Command inputs
    input wire logic [ADDR_W-1:0] ADDRESS,
    input wire logic READ_WRITE,
    input wire logic ADVANCE_OR_LOAD_N,
    input wire logic CLOCK_ENABLE_N,
    input wire logic CHIP_SELECT_FIRST_N,
    input wire logic CHIP_SELECT_SECOND_N,
    input wire logic CHIP_SELECT_THIRD_HIGH,
    input wire logic [LANES-1:0] BYTE_WRITE_N,
    // Static strap and asynchronous output enable
    input wire logic BURST_ORDER_SELECT,
    input wire logic OUTPUT_ENABLE_N,
    // Data pins, split into input, output and enable
    input wire logic [LANES*ZSP_LANE_BITS-1:0] DQ_IN,
    output logic [LANES*ZSP_LANE_BITS-1:0] DQ_OUT,
    output logic DQ_OE,
    // Parity pins, one per lane
    input wire logic [LANES-1:0] PARITY_IN,
    output logic [LANES-1:0] PARITY_OUT,
    output logic PARITY_OE
);

    localparam int WORD_W = LANES * ZSP_LANE_STORE;

    zsp_state_t st_r;
    zsp_state_t st_nxt;
    logic [WORD_W-1:0] mem [2**ADDR_W];
    logic advance;
    logic selected;
    logic [WORD_W-1:0] rd_word;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [WORD_W-1:0] fifo_out_data;
    logic fifo_push;
    logic fifo_pop;
    logic wr_commit;
    logic [WORD_W-1:0] wr_word;
    logic dq_drive;

    // Stage s1 holds the command taken on the last enabled edge and reads the
    // array. Stage s2 holds the one before it, whose write data stands on the
    // pins now. A read word passes through the buffer into the output register
    // on the edge that retires s2, two enabled edges after its load.
    // Suspended edges move none of this, which keeps driven data on the bus.

    function automatic logic chip_selected(input logic cs1_n, input logic cs2_n,
                                           input logic cs3);
        chip_selected = !cs1_n && !cs2_n && cs3;
    endfunction

    // Low address bits of a burst beat from the start bits and beat number.
    function automatic logic [1:0] burst_lo(input logic [1:0] start,
                                            input logic [1:0] beat,
                                            input logic interleaved);
        if (interleaved) begin
            burst_lo = start ^ beat;
        end else begin
            burst_lo = start + beat;
        end
    endfunction

    // Overlays the lanes of a write that commits on the same edge.
    function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] old,
                                                input logic [LANES*ZSP_LANE_BITS-1:0] din,
                                                input logic [LANES-1:0] pin,
                                                input logic [LANES-1:0] bw_n);
        logic [WORD_W-1:0] word;
        word = old;
        for (int i = 0; i < LANES; i++) begin
            if (!bw_n[i]) begin
                word[i*ZSP_LANE_STORE +: ZSP_LANE_STORE] =
                    {pin[i], din[i*ZSP_LANE_BITS +: ZSP_LANE_BITS]};
            end
        end
        merge = word;
    endfunction

    // Byte of one lane out of a stored word, its parity left behind.
    function automatic logic [ZSP_LANE_BITS-1:0] lane_byte(input logic [WORD_W-1:0] word,
                                                            input int lane);
        lane_byte = word[lane*ZSP_LANE_STORE +: ZSP_LANE_BITS];
    endfunction

    // Parity bit of one lane, kept just above its byte.
    function automatic logic lane_parity(input logic [WORD_W-1:0] word, input int lane);
        lane_parity = word[lane*ZSP_LANE_STORE + ZSP_LANE_BITS];
    endfunction

    // A full read buffer stalls the whole pipeline like a suspended edge.
    assign advance = !CLOCK_ENABLE_N && fifo_in_ready;
    assign selected = chip_selected(CHIP_SELECT_FIRST_N, CHIP_SELECT_SECOND_N,
                                    CHIP_SELECT_THIRD_HIGH);

    // A read in stage one must see a write in stage two that commits now.
    always_comb begin
        rd_word = mem[st_r.s1.addr[ADDR_W-1:0]];
        if (st_r.s2.op == ZSP_WRITE && st_r.s2.addr == st_r.s1.addr) begin
            rd_word = merge(rd_word, DQ_IN, PARITY_IN, st_r.s2.bw_n[LANES-1:0]);
        end
    end

    // The burst counter counts beats, not addresses, so the wrap back to the
    // loaded low bits falls out of the two-bit overflow in either order.

    assign fifo_push = advance && (st_r.s1.op == ZSP_READ);
    assign fifo_pop = advance && (st_r.s2.op == ZSP_READ);

    zsp_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(BUF_DEPTH)
    ) u_read_buf (
        .clk(CLK_SYS),
        .rst_n(RESET_N),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(rd_word),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    always_comb begin
        logic [1:0] beat;
        zsp_cmd_t cmd;
        beat = st_r.cnt + ZSP_BURST_STEP;
        cmd = ZSP_CMD_IDLE;
        st_nxt = st_r;
        // Without an advance nothing moves, so driven data stays put.
        if (advance) begin
            if (!ADVANCE_OR_LOAD_N) begin
                if (selected) begin
                    cmd.op = READ_WRITE ? ZSP_READ : ZSP_WRITE;
                    cmd.addr = ZSP_ADDR_MAX'(ADDRESS);
                    cmd.bw_n = ZSP_LANES_MAX'(BYTE_WRITE_N);
                    st_nxt.burst = cmd.op;
                    st_nxt.base = cmd.addr;
                    st_nxt.start = ADDRESS[1:0];
                    st_nxt.cnt = ZSP_BURST_CNT_RST;
                end else begin
                    st_nxt.burst = ZSP_IDLE;
                end
            end else begin
                case (st_r.burst)
                    ZSP_READ, ZSP_WRITE: begin
                        // Read/write is not looked at here.
                        cmd.op = st_r.burst;
                        cmd.addr = {st_r.base[ZSP_ADDR_MAX-1:2],
                                    burst_lo(st_r.start, beat, BURST_ORDER_SELECT)};
                        cmd.bw_n = ZSP_LANES_MAX'(BYTE_WRITE_N);
                        st_nxt.cnt = beat;
                    end
                    default: begin
                        cmd = ZSP_CMD_IDLE;
                    end
                endcase
            end
            st_nxt.s1 = cmd;
            st_nxt.s2 = st_r.s1;
            // Deselects and no-ops leave the bus floating two edges on.
            st_nxt.oe = (st_r.s2.op == ZSP_READ) && fifo_out_valid;
            if (st_r.s2.op == ZSP_READ) begin
                for (int i = 0; i < LANES; i++) begin
                    st_nxt.dq[i*ZSP_LANE_BITS +: ZSP_LANE_BITS] = lane_byte(fifo_out_data, i);
                    st_nxt.par[i] = lane_parity(fifo_out_data, i);
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            st_r.burst <= ZSP_IDLE;
            st_r.base <= '0;
            st_r.start <= ZSP_BURST_CNT_RST;
            st_r.cnt <= ZSP_BURST_CNT_RST;
            st_r.s1 <= ZSP_CMD_IDLE;
            st_r.s2 <= ZSP_CMD_IDLE;
            st_r.dq <= '0;
            st_r.par <= '0;
            st_r.oe <= ZSP_OE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Write data is sampled on the edge two after its command. Lanes with
    // their byte write high are left alone, and reads never write.
    // A suspended edge must not commit, or the write would land twice once
    // the controller repeats its data phase.
    assign wr_commit = advance && (st_r.s2.op == ZSP_WRITE);
    assign wr_word = merge(mem[st_r.s2.addr[ADDR_W-1:0]], DQ_IN, PARITY_IN,
                           st_r.s2.bw_n[LANES-1:0]);

    always_ff @(posedge CLK_SYS) begin
        if (wr_commit) begin
            mem[st_r.s2.addr[ADDR_W-1:0]] <= wr_word;
        end
    end

    // Output enable acts without the clock, so it gates the pins directly.
    // Data and parity pins share one enable so a lane never half drives.
    assign dq_drive = st_r.oe && !OUTPUT_ENABLE_N;
    assign DQ_OUT = st_r.dq[LANES*ZSP_LANE_BITS-1:0];
    assign PARITY_OUT = st_r.par[LANES-1:0];
    assign DQ_OE = dq_drive;
    assign PARITY_OE = dq_drive;

endmodule // zsp_sram_port

//--- verification/testbench.sv
// Self-checking bench for the pipelined SRAM port.
`timescale 1ns/1ps

module testbench;
    localparam logic [2:0] SEL = 3'b001;
    logic clk_sys, reset_n, rw, adv_n, cen_n, bos, wr, hi, dq_oe, par_oe, oe_n;
    logic [2:0] cs;
    logic [18:0] addr;
    logic [3:0] bw_n, par_in, par_out;
    logic [31:0] dq_in, dq_out;
    logic [35:0] dat;
    logic [36:0] e1, e2, cur;
    int n_mismatch, checks;

    zsp_sram_port u_zsp_sram_port (.CLK_SYS(clk_sys), .RESET_N(reset_n), .ADDRESS(addr),
        .READ_WRITE(rw), .ADVANCE_OR_LOAD_N(adv_n), .CLOCK_ENABLE_N(cen_n),
        .CHIP_SELECT_FIRST_N(cs[2]), .CHIP_SELECT_SECOND_N(cs[1]), .CHIP_SELECT_THIRD_HIGH(cs[0]),
        .BYTE_WRITE_N(bw_n), .BURST_ORDER_SELECT(bos), .OUTPUT_ENABLE_N(oe_n), .DQ_IN(dq_in),
        .DQ_OUT(dq_out), .DQ_OE(dq_oe), .PARITY_IN(par_in), .PARITY_OUT(par_out),
        .PARITY_OE(par_oe));
    zsp_ctrl_model u_zsp_ctrl_model (.clk(clk_sys), .rst_n(reset_n), .cen_n(cen_n), .wr_cmd(wr),
        .wr_data(dat), .dq(dq_in), .par(par_in), .oe_n(oe_n));

    function automatic logic [35:0] pat(input logic [18:0] a);
        return {a[3:0] ^ 4'h9, 13'h1A5B, a};
    endfunction

    task automatic check(input logic [36:0] seen, input logic [36:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic go(input logic a_n, input logic r, input logic [2:0] c, input logic [18:0] a,
                      input logic [3:0] b, input logic w, input logic h, input logic [35:0] d);
        adv_n <= a_n;
        rw <= r;
        cs <= c;
        addr <= a;
        bw_n <= b;
        wr <= w;
        hi <= h;
        dat <= d;
        @(posedge clk_sys);
    endtask

    task automatic ldw(input logic [18:0] a, input logic [3:0] b, input logic [35:0] d);
        go(1'b0, 1'b0, SEL, a, b, 1'b1, 1'b0, d);
    endtask

    task automatic ldr(input logic [18:0] a, input logic [35:0] d);
        go(1'b0, 1'b1, SEL, a, 4'h0, 1'b0, 1'b1, d);
    endtask

    task automatic idle(input int n);
        // Deselects carry an active write request that must be dropped.
        repeat (n) go(1'b0, 1'b0, 3'b101, 19'h0, 4'h0, 1'b0, 1'b0, 36'h0);
    endtask

    task automatic sus(input int n);
        cen_n <= 1'b1;
        addr <= 19'h7FFFF;
        rw <= 1'b0;
        repeat (n) @(posedge clk_sys);
        cen_n <= 1'b0;
    endtask

    task automatic t_lanes();
        ldw(19'h00100, 4'h0, pat(19'h00100));
        ldw(19'h00100, 4'hA, 36'hF_FFFF_FFFF);
        ldw(19'h00100, 4'hF, 36'h0);
        ldr(19'h00100, pat(19'h00100) | 36'h5_00FF_00FF);
        idle(3);
    endtask

    task automatic t_burst(input logic o);
        logic [1:0] bt;
        bos <= o;
        for (int i = 0; i < 4; i++) ldw(19'h00200 + 19'(i), 4'h0, pat(19'h00200 + 19'(i)));
        ldr(19'h00201, pat(19'h00201));
        for (int b = 1; b < 6; b++) begin
            bt = o ? 2'(1 ^ b) : 2'(1 + b);
            go(1'b1, 1'b0, 3'b000, 19'h0, 4'h0, 1'b0, 1'b1, pat({17'h00080, bt}));
        end
        idle(3);
    endtask

    task automatic t_bwrite();
        logic [18:0] a;
        bos <= 1'b0;
        ldw(19'h00301, 4'h0, pat(19'h00301));
        ldw(19'h00302, 4'h0, ~pat(19'h00302));
        for (int b = 1; b < 4; b++) begin
            a = {17'h000C0, 2'(2 + b)};
            go(1'b1, 1'b1, 3'b000, 19'h0, (b == 3) ? 4'hE : 4'h0, 1'b1, 1'b0, ~pat(a));
        end
        for (int i = 0; i < 4; i++) begin
            a = 19'h00300 + 19'(i);
            ldr(a, (i == 1) ? pat(a) ^ 36'h1_0000_00FF : ~pat(a));
        end
        idle(3);
    endtask

    task automatic t_susp();
        ldr(19'h00200, pat(19'h00200));
        sus(2);
        idle(1);
        sus(1);
        idle(1);
        sus(2);
        idle(3);
    endtask

    task automatic t_desel();
        for (int i = 0; i < 3; i++) begin
            go(1'b0, 1'b1, {i == 0, i == 1, i != 2}, 19'h00200, 4'h0, 1'b0, 1'b0, 36'h0);
            go(1'b1, 1'b1, SEL, 19'h00200, 4'h0, 1'b0, 1'b0, 36'h0);
        end
        ldr(19'h00200, pat(19'h00200));
        idle(3);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Expected pins per enabled edge ride a two-stage queue, mirroring the data phase.
    always @(posedge clk_sys) begin
        cur = cen_n ? {dq_oe, par_out, dq_out} : e2;
        if (reset_n && !cen_n) begin
            e2 <= e1;
            e1 <= {hi, dat};
        end
        #1;
        if (reset_n) check({dq_oe, {par_out, dq_out} & {36{cur[36]}}},
                           cur & {1'b1, {36{cur[36]}}});
        if (reset_n) check({36'h0, par_oe}, {36'h0, cur[36]});
    end

    initial begin
        repeat (3000) @(posedge clk_sys);
        n_mismatch++;
        finish_test();
    end

    initial begin
        {reset_n, cen_n, adv_n, rw, wr, hi, bos, addr, dat, e1, e2} = '0;
        cs = 3'b101;
        bw_n = 4'hF;
        n_mismatch = 0;
        checks = 0;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_lanes();
        t_burst(1'b0);
        t_burst(1'b1);
        t_bwrite();
        t_susp();
        t_desel();
        finish_test();
    end
endmodule // testbench

//--- verification/zsp_ctrl_model.sv
// Memory controller model that supplies write data to the SRAM port.
`timescale 1ns/1ps

module zsp_ctrl_model (
    // Clock, reset and command slots from the bench
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cen_n,
    input wire logic wr_cmd,
    input wire logic [35:0] wr_data,
    // Pins toward the port
    output logic [31:0] dq,
    output logic [3:0] par,
    output logic oe_n
);
    logic [36:0] s1_r;
    logic [36:0] s2_r;
    logic [35:0] last_r;

    // Slots advance on enabled edges only, so a suspend stretches the data phase too.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            last_r <= '0;
        end else if (!cen_n) begin
            s1_r <= {wr_cmd, wr_data};
            s2_r <= s1_r;
            if (s2_r[36]) begin
                last_r <= s2_r[35:0];
            end
        end
    end

    // A released bus shows the inverse of the last word, so stale data never looks valid.
    assign {par, dq} = s2_r[36] ? s2_r[35:0] : ~last_r;
    // Output enable is kept high in our own write slots so two drivers never fight.
    assign oe_n = s2_r[36];
endmodule // zsp_ctrl_model

//--- verification/zsp_sram_port_chk.sv
// Pin-level assertions for the SRAM port.
`timescale 1ns/1ps

module zsp_sram_port_chk
    import zsp_pkg::*;
#(
    parameter int LANES = ZSP_LANES
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // Commands
    input wire logic READ_WRITE,
    input wire logic ADVANCE_OR_LOAD_N,
    input wire logic CLOCK_ENABLE_N,
    input wire logic CHIP_SELECT_FIRST_N,
    input wire logic CHIP_SELECT_SECOND_N,
    input wire logic CHIP_SELECT_THIRD_HIGH,
    input wire logic OUTPUT_ENABLE_N,
    // Data side
    input wire logic [LANES*ZSP_LANE_BITS-1:0] DQ_OUT,
    input wire logic DQ_OE,
    input wire logic [LANES-1:0] PARITY_OUT,
    input wire logic PARITY_OE
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESET_N);

    logic en;
    logic sel;
    logic ld;
    assign en = !CLOCK_ENABLE_N;
    assign sel = !CHIP_SELECT_FIRST_N && !CHIP_SELECT_SECOND_N && CHIP_SELECT_THIRD_HIGH;
    assign ld = en && !ADVANCE_OR_LOAD_N;

    reset_float_a: assert property ($rose(RESET_N) |-> !DQ_OE [*3])
        else $error("data driven after reset");
    suspend_hold_a: assert property (CLOCK_ENABLE_N |=> $stable({DQ_OUT, PARITY_OUT}))
        else $error("output moved on a suspended edge");
    oe_gate_a: assert property (PARITY_OE == DQ_OE && (OUTPUT_ENABLE_N -> !DQ_OE))
        else $error("output enable gating wrong");
    oe_hold_a: assert property (CLOCK_ENABLE_N && !OUTPUT_ENABLE_N
        ##1 !OUTPUT_ENABLE_N |-> $stable(DQ_OE)) else $error("enable moved on suspend");
    deselect_float_a: assert property (ld && !sel ##1 en ##1 en |=> !DQ_OE)
        else $error("bus driven after deselect");
    read_drive_a: assert property (ld && sel && READ_WRITE ##1 en ##1 en
        |=> DQ_OE || OUTPUT_ENABLE_N) else $error("read data missing");
    write_float_a: assert property (ld && sel && !READ_WRITE ##1 en ##1 en |=> !DQ_OE)
        else $error("bus driven in write slot");
    no_operation_cycle_float_a: assert property (ld && !sel ##1 en && ADVANCE_OR_LOAD_N ##1 en ##1 en
        |=> !DQ_OE) else $error("bus driven after no-op");
endmodule // zsp_sram_port_chk

bind zsp_sram_port zsp_sram_port_chk #(.LANES(LANES)) u_zsp_sram_port_chk (.CLK_SYS, .RESET_N,
    .READ_WRITE, .ADVANCE_OR_LOAD_N, .CLOCK_ENABLE_N, .CHIP_SELECT_FIRST_N,
    .CHIP_SELECT_SECOND_N, .CHIP_SELECT_THIRD_HIGH, .OUTPUT_ENABLE_N, .DQ_OUT, .DQ_OE,
    .PARITY_OUT, .PARITY_OE);
